// ===== include/cmoc_pkg.sv
/*
 Constants and types for the CAN operating-mode controller.
 Assumes a single 25 MHz system clock and a CAN bit rate set by a bit time.
*/
package cmoc_pkg;
	localparam int CLK_HZ = 25_000_000;
	// Nominal bit time in ns (1 Mbit/s)
	localparam int BIT_TIME_NS = 1000;
	localparam int BIT_CYCLES = (BIT_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int IDLE_BITS = 11;
	localparam int STD_ID_W = 11;
	localparam int EXT_ID_W = 29;
	// Received word layout: identifier in the low bits, frame-format flag above
	localparam int WORD_W = 32;
	localparam int ID_LSB = 0;
	localparam int STD_ID_LSB = EXT_ID_W - STD_ID_W;
	localparam int IDE_BIT = 29;
	localparam int RTR_BIT = 30;
	localparam int FIFO_DEPTH = 16;
	localparam logic RECESSIVE = 1'h1;
	localparam logic DOMINANT = 1'h0;
	localparam logic [3:0] RST_STATE = 4'h1;

	typedef enum logic [3:0] {
		ST_SLEEP = 4'h1,
		ST_INIT = 4'h2,
		ST_SYNC = 4'h4,
		ST_NORMAL = 4'h8
	} cmoc_state_t;
endpackage

// ===== include/cmoc_stream_if.sv
/*
 Valid/ready word stream between the mode controller and its buffer.
 Assumes both ends on sys_clk; a word moves when valid and ready are both high.
*/
`timescale 1ns/1ns
`default_nettype none
interface cmoc_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== core/cmoc_fifo.sv
/*
 Synchronous FIFO with a registered output stage.
 Assumes one clock; the drain side may hold ready low to stall.
*/
`timescale 1ns/1ns
`default_nettype none
module cmoc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Fill and drain sides
	cmoc_stream_if.snk in_s,
	cmoc_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic in_ready_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic push;
	logic pop;

	assign push = in_s.valid && in_ready_ff;
	// Refill the output stage when it is empty or being taken
	assign pop = (count_ff != '0) && (!out_valid_ff || out_s.ready);
	assign in_s.ready = in_ready_ff;
	assign out_s.valid = out_valid_ff;
	assign out_s.data = out_data_ff;

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_s.data;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'h0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= nxt_count;
			// Registered ready is honest: it only rises once a slot is free
			in_ready_ff <= nxt_count < DEPTH_C;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_valid_ff <= 1'h0;
			out_data_ff <= '0;
		end else if (pop) begin
			out_valid_ff <= 1'h1;
			out_data_ff <= mem_ff[rd_ptr_ff];
		end else if (out_s.ready) begin
			out_valid_ff <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// ===== core/cmoc_mode_ctrl.sv
/*
 Operating-mode controller of a CAN 2.0A/B node: sleep, initialization and
 normal modes, bus-idle synchronisation, wake-up, silent and loop-back paths,
 and a buffered path for received frame words.
 Assumes a protocol core on sys_clk that obeys core_clk_enable and core_bus_on,
 and software that keeps its request and test-select bits as levels.
*/
`timescale 1ns/1ns
`default_nettype none
module cmoc_mode_ctrl import cmoc_pkg::*; #(
	parameter int BIT_CYC = BIT_CYCLES,
	parameter int IDLE_N = IDLE_BITS,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Software control bits
	input wire logic init_request,
	input wire logic sleep_request,
	input wire logic auto_wake_select,
	input wire logic wake_irq_enable,
	input wire logic listen_only_select,
	input wire logic self_loop_select,
	// Software status
	output logic init_acknowledge,
	output logic lowpower_acknowledge,
	output logic sleep_request_clear,
	output logic wake_irq,
	// Bus pins
	input wire logic bus_receive_pin,
	output logic bus_transmit_pin,
	output logic rx_pullup_enable,
	// Protocol core
	input wire logic core_tx,
	input wire logic core_frame_active,
	output logic core_rx,
	output logic core_clk_enable,
	output logic core_bus_on,
	output logic core_tx_allowed,
	output logic core_ack_err_ignore,
	// Received frame words from the core
	input wire logic rx_word_valid,
	input wire logic [WORD_W-1:0] rx_word_data,
	output logic rx_word_ready,
	// Received frame words to the mailbox
	output logic mbox_valid,
	output logic [WORD_W-1:0] mbox_data,
	input wire logic mbox_ready
);
	localparam int DW = $clog2(BIT_CYC + 1);
	localparam int IW = $clog2(IDLE_N + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYC - 1);
	localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_N);

	cmoc_state_t state_ff;
	cmoc_state_t nxt_state;
	logic rx_meta_ff;
	logic rx_sync_ff;
	logic rx_prev_ff;
	logic [DW-1:0] div_ff;
	logic bit_tick;
	logic [IW-1:0] idle_cnt_ff;
	logic idle_seen;
	logic sync_rx;
	logic wake_hit;
	logic init_ack_ff;
	logic lp_ack_ff;
	logic pullup_ff;
	logic sleep_clr_ff;
	logic wake_irq_ff;
	logic tx_pin_ff;
	logic core_rx_ff;
	logic clk_en_ff;
	logic bus_on_ff;
	logic tx_ok_ff;
	logic ack_ign_ff;
	logic accept;

	cmoc_stream_if #(.W(WORD_W)) fill_s ();
	cmoc_stream_if #(.W(WORD_W)) drain_s ();

	// Receive pin crosses in from the bus: two flops before any use
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_meta_ff <= RECESSIVE;
			rx_sync_ff <= RECESSIVE;
			rx_prev_ff <= RECESSIVE;
		end else begin
			rx_meta_ff <= bus_receive_pin;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	// Bit-rate enable; the free-running divider only approximates bit sampling
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= '0;
		end else if (div_ff == DIV_LAST) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end
	assign bit_tick = (div_ff == DIV_LAST);

	// In loop-back the pin is disregarded, so the line looks idle
	assign sync_rx = self_loop_select ? RECESSIVE : rx_sync_ff;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt_ff <= '0;
		end else if (state_ff != ST_SYNC) begin
			idle_cnt_ff <= '0;
		end else if (bit_tick) begin
			if (sync_rx == DOMINANT) begin
				idle_cnt_ff <= '0;
			end else if (idle_cnt_ff != IDLE_LAST) begin
				idle_cnt_ff <= idle_cnt_ff + 1'b1;
			end
		end
	end
	assign idle_seen = (idle_cnt_ff == IDLE_LAST);

	// Falling edge to dominant; this logic stays clocked in sleep
	assign wake_hit = (state_ff == ST_SLEEP) && rx_prev_ff && !rx_sync_ff;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_SLEEP: begin
				// Init request is ignored here and never acknowledged
				if (!sleep_request || (wake_hit && auto_wake_select)) begin
					nxt_state = ST_SYNC;
				end
			end
			ST_INIT: begin
				if (sleep_request) begin
					nxt_state = ST_SLEEP;
				end else if (!init_request) begin
					nxt_state = ST_SYNC;
				end
			end
			ST_SYNC: begin
				// After an auto wake the sleep bit clears one edge after the pulse; do not fall back asleep
				if (init_request) begin
					nxt_state = ST_INIT;
				end else if (sleep_request && !sleep_clr_ff) begin
					nxt_state = ST_SLEEP;
				end else if (idle_seen) begin
					nxt_state = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				// A frame in progress is finished before the mode changes
				if (!core_frame_active && init_request) begin
					nxt_state = ST_INIT;
				end else if (!core_frame_active && sleep_request) begin
					nxt_state = ST_SLEEP;
				end
			end
			default: begin
				nxt_state = ST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_SLEEP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Acknowledges follow the mode actually held; sync keeps the old one
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			init_ack_ff <= 1'h0;
			lp_ack_ff <= 1'h1;
			pullup_ff <= 1'h1;
		end else if (nxt_state != state_ff) begin
			unique case (nxt_state)
				ST_INIT: begin
					init_ack_ff <= 1'h1;
					lp_ack_ff <= 1'h0;
					pullup_ff <= 1'h0;
				end
				ST_SLEEP: begin
					init_ack_ff <= 1'h0;
					lp_ack_ff <= 1'h1;
					pullup_ff <= 1'h0;
				end
				ST_NORMAL: begin
					init_ack_ff <= 1'h0;
					lp_ack_ff <= 1'h0;
				end
				ST_SYNC: begin
					init_ack_ff <= init_ack_ff;
					lp_ack_ff <= lp_ack_ff;
				end
				default: begin
					init_ack_ff <= 1'h0;
					lp_ack_ff <= 1'h1;
				end
			endcase
		end
	end

	// Wake events: one-cycle pulses to the software register side
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_clr_ff <= 1'h0;
			wake_irq_ff <= 1'h0;
		end else begin
			sleep_clr_ff <= wake_hit && auto_wake_select;
			wake_irq_ff <= wake_hit && wake_irq_enable;
		end
	end

	// Core control; configuration inputs are never touched here
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_en_ff <= 1'h0;
			bus_on_ff <= 1'h0;
			tx_ok_ff <= 1'h0;
			ack_ign_ff <= 1'h0;
		end else begin
			// Gating the core clock freezes every core status bit
			clk_en_ff <= (nxt_state != ST_SLEEP);
			bus_on_ff <= (nxt_state == ST_NORMAL);
			tx_ok_ff <= (nxt_state == ST_NORMAL) && !listen_only_select;
			ack_ign_ff <= self_loop_select;
		end
	end

	// Transmit pin and the core's receive view
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_pin_ff <= RECESSIVE;
			core_rx_ff <= RECESSIVE;
		end else begin
			if (nxt_state != ST_NORMAL) begin
				tx_pin_ff <= RECESSIVE;
			end else if (listen_only_select) begin
				tx_pin_ff <= RECESSIVE;
			end else begin
				tx_pin_ff <= core_tx;
			end
			if (self_loop_select) begin
				core_rx_ff <= core_tx;
			end else if (listen_only_select) begin
				core_rx_ff <= rx_sync_ff & core_tx;
			end else begin
				core_rx_ff <= rx_sync_ff;
			end
		end
	end

	// Words hold 11-bit or 29-bit identifiers with a format flag
	assign accept = (state_ff == ST_NORMAL);
	assign fill_s.valid = rx_word_valid && accept;
	assign fill_s.data = rx_word_data;
	assign drain_s.ready = mbox_ready;

	cmoc_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(DEPTH)
	) cmoc_fifo_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_s(fill_s),
		.out_s(drain_s)
	);

	assign init_acknowledge = init_ack_ff;
	assign lowpower_acknowledge = lp_ack_ff;
	assign sleep_request_clear = sleep_clr_ff;
	assign wake_irq = wake_irq_ff;
	assign bus_transmit_pin = tx_pin_ff;
	assign rx_pullup_enable = pullup_ff;
	assign core_rx = core_rx_ff;
	assign core_clk_enable = clk_en_ff;
	assign core_bus_on = bus_on_ff;
	assign core_tx_allowed = tx_ok_ff;
	assign core_ack_err_ignore = ack_ign_ff;
	assign rx_word_ready = fill_s.ready;
	assign mbox_valid = drain_s.valid;
	assign mbox_data = drain_s.data;
endmodule
`default_nettype wire

// ===== verification/cmoc_bus_model.sv
/*
 CAN bus stand-in: the other nodes pull the bus dominant on demand.
 Assumes one node's pins; a released bus is held recessive.
*/
`timescale 1ns/1ns
`default_nettype none
module cmoc_bus_model (
	// Node pins
	input wire logic bus_transmit_pin,
	output logic bus_receive_pin,
	// Other nodes
	input wire logic node_dom
);
	// Wired-AND: dominant wins over the node's own bit
	assign bus_receive_pin = bus_transmit_pin & ~node_dom;
endmodule
`default_nettype wire

// ===== verification/cmoc_mode_ctrl_assertions.sv
/*
 Port assertions of the mode controller.
 Assumes binding to cmoc_mode_ctrl, all on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cmoc_mode_ctrl_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic init_acknowledge,
	input wire logic lowpower_acknowledge,
	input wire logic sleep_request_clear,
	input wire logic wake_irq,
	input wire logic wake_irq_enable,
	input wire logic auto_wake_select,
	input wire logic listen_only_select,
	input wire logic self_loop_select,
	input wire logic bus_receive_pin,
	input wire logic bus_transmit_pin,
	input wire logic rx_pullup_enable,
	input wire logic core_tx,
	input wire logic core_rx,
	input wire logic core_clk_enable,
	input wire logic core_bus_on,
	input wire logic core_tx_allowed,
	input wire logic core_ack_err_ignore
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_acks_exclusive: assert property (!(init_acknowledge && lowpower_acknowledge))
		else $error("both acknowledges set");
	chk_bus_on_normal: assert property (core_bus_on |-> !init_acknowledge && !lowpower_acknowledge)
		else $error("bus on outside normal");
	chk_init_quiet: assert property (init_acknowledge && $past(init_acknowledge)
		|-> bus_transmit_pin && !core_tx_allowed && !core_bus_on) else $error("traffic in init");
	chk_pullup_drop: assert property ($rose(init_acknowledge) || $rose(lowpower_acknowledge)
		|-> ##[0:1] !rx_pullup_enable) else $error("pull-up kept");
	chk_sleep_no_init: assert property (!core_clk_enable |=> !init_acknowledge)
		else $error("init acked in sleep");
	chk_sleep_idle: assert property (!core_clk_enable
		|-> !core_bus_on && bus_transmit_pin && lowpower_acknowledge) else $error("sleep not idle");
	chk_wake_pulse: assert property (wake_irq
		|-> wake_irq_enable && !$past(bus_receive_pin, 2) ##1 !wake_irq) else $error("bad wake pulse");
	chk_auto_clear: assert property (sleep_request_clear
		|-> auto_wake_select && core_clk_enable ##1 !sleep_request_clear) else $error("bad auto clear");
	chk_loop_path: assert property (core_bus_on && self_loop_select && !listen_only_select ##1 core_bus_on
		|-> core_rx == $past(core_tx) && bus_transmit_pin == $past(core_tx)) else $error("loop path wrong");
	chk_silent_recess: assert property (core_bus_on && listen_only_select
		|=> bus_transmit_pin && !core_tx_allowed) else $error("silent node drove bus");
	chk_ack_ignore: assert property ($past(reset_n)
		|-> core_ack_err_ignore == $past(self_loop_select)) else $error("ack ignore wrong");
endmodule
bind cmoc_mode_ctrl cmoc_mode_ctrl_assertions cmoc_mode_ctrl_assertions_inst (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.init_acknowledge(init_acknowledge),
	.lowpower_acknowledge(lowpower_acknowledge),
	.sleep_request_clear(sleep_request_clear),
	.wake_irq(wake_irq),
	.wake_irq_enable(wake_irq_enable),
	.auto_wake_select(auto_wake_select),
	.listen_only_select(listen_only_select),
	.self_loop_select(self_loop_select),
	.bus_receive_pin(bus_receive_pin),
	.bus_transmit_pin(bus_transmit_pin),
	.rx_pullup_enable(rx_pullup_enable),
	.core_tx(core_tx),
	.core_rx(core_rx),
	.core_clk_enable(core_clk_enable),
	.core_bus_on(core_bus_on),
	.core_tx_allowed(core_tx_allowed),
	.core_ack_err_ignore(core_ack_err_ignore)
);
`default_nettype wire

// ===== verification/can_operating_mode_control_bench.sv
/*
 Self-checking bench of the mode controller with a bus model.
 Assumes cmoc_pkg compiled first; bit time shortened to 4 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module can_operating_mode_control_bench import cmoc_pkg::*;;
	localparam int BC = 4;
	localparam logic [WORD_W-1:0] K = 32'h2000_0801;
	logic sys_clk = 1'h0, reset_n = 1'h0, init_request = 1'h0, sleep_request = 1'h1;
	logic auto_wake_select = 1'h0, wake_irq_enable = 1'h0, listen_only_select = 1'h0;
	logic self_loop_select = 1'h0, core_tx = 1'h1, core_frame_active = 1'h0;
	logic rx_word_valid = 1'h0, mbox_ready = 1'h0, node_dom = 1'h0;
	logic [WORD_W-1:0] rx_word_data = '0, mbox_data;
	logic init_acknowledge, lowpower_acknowledge, sleep_request_clear, wake_irq, bus_receive_pin;
	logic bus_transmit_pin, rx_pullup_enable, core_rx, core_clk_enable, core_bus_on;
	logic core_tx_allowed, core_ack_err_ignore, rx_word_ready, mbox_valid;
	int n_mismatch = 0, check_count = 0, cyc = 0, n, i;
	// listen, loop, core_tx, other node dominant, expected pin, expected core_rx
	logic [5:0] rows [9] = '{6'h00, 6'h0e, 6'h0b, 6'h22, 6'h2e, 6'h1f, 6'h10, 6'h32, 6'h3f};

	cmoc_mode_ctrl #(.BIT_CYC(BC)) cmoc_mode_ctrl_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.init_request(init_request),
		.sleep_request(sleep_request),
		.auto_wake_select(auto_wake_select),
		.wake_irq_enable(wake_irq_enable),
		.listen_only_select(listen_only_select),
		.self_loop_select(self_loop_select),
		.init_acknowledge(init_acknowledge),
		.lowpower_acknowledge(lowpower_acknowledge),
		.sleep_request_clear(sleep_request_clear),
		.wake_irq(wake_irq),
		.bus_receive_pin(bus_receive_pin),
		.bus_transmit_pin(bus_transmit_pin),
		.rx_pullup_enable(rx_pullup_enable),
		.core_tx(core_tx),
		.core_frame_active(core_frame_active),
		.core_rx(core_rx),
		.core_clk_enable(core_clk_enable),
		.core_bus_on(core_bus_on),
		.core_tx_allowed(core_tx_allowed),
		.core_ack_err_ignore(core_ack_err_ignore),
		.rx_word_valid(rx_word_valid),
		.rx_word_data(rx_word_data),
		.rx_word_ready(rx_word_ready),
		.mbox_valid(mbox_valid),
		.mbox_data(mbox_data),
		.mbox_ready(mbox_ready)
	);
	cmoc_bus_model cmoc_bus_model_inst (
		.bus_transmit_pin(bus_transmit_pin),
		.bus_receive_pin(bus_receive_pin),
		.node_dom(node_dom)
	);

	always #20 sys_clk = ~sys_clk;

	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		// Whole run is about 800 cycles
		if (cyc == 6000) begin
			n_mismatch = n_mismatch + 1;
			close_out();
		end
	end

	task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	task automatic till(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		// A wait that runs out is a failure in its own right
		if (n >= 400) begin
			n_mismatch++;
			close_out();
		end
	endtask

	// Sync needs 11 idle bits on a free-running bit tick
	task automatic settle(ref logic ack);
		till(ack, 1'h0);
		chk_bit(n > 10 * BC && n <= 13 * BC, 1'h1);
	endtask

	task automatic to_normal(input logic l, input logic b);
		@(posedge sys_clk) init_request <= 1'h1;
		till(init_acknowledge, 1'h1);
		chk_bit(rx_pullup_enable, 1'h0);
		chk_bit(bus_transmit_pin, 1'h1);
		@(posedge sys_clk) listen_only_select <= l;
		self_loop_select <= b;
		@(posedge sys_clk) init_request <= 1'h0;
		settle(init_acknowledge);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'h1;
		@(negedge sys_clk);
		chk_bit(lowpower_acknowledge, 1'h1);
		chk_bit(rx_pullup_enable, 1'h1);
		chk_bit(core_clk_enable, 1'h0);
		@(posedge sys_clk) init_request <= 1'h1;
		repeat (10) @(negedge sys_clk);
		chk_bit(init_acknowledge, 1'h0);
		@(posedge sys_clk) sleep_request <= 1'h0;
		till(init_acknowledge, 1'h1);
		chk_bit(lowpower_acknowledge, 1'h0);
		foreach (rows[k]) begin
			to_normal(rows[k][5], rows[k][4]);
			@(posedge sys_clk) core_tx <= rows[k][3];
			node_dom <= rows[k][2];
			repeat (6) @(negedge sys_clk);
			chk_bit(bus_transmit_pin, rows[k][1]);
			chk_bit(core_rx, rows[k][0]);
			chk_bit(core_bus_on, 1'h1);
			chk_bit(core_tx_allowed, ~rows[k][5]);
			chk_bit(core_ack_err_ignore, rows[k][4]);
			@(posedge sys_clk) core_tx <= 1'h1;
			node_dom <= 1'h0;
		end
		// Auto wake: hardware asks for the sleep bit to be cleared; a frame in flight delays sleep
		@(posedge sys_clk) sleep_request <= 1'h1;
		core_frame_active <= 1'h1;
		auto_wake_select <= 1'h1;
		wake_irq_enable <= 1'h1;
		repeat (4) @(negedge sys_clk);
		chk_bit(lowpower_acknowledge, 1'h0);
		@(posedge sys_clk) core_frame_active <= 1'h0;
		till(core_clk_enable, 1'h0);
		chk_bit(lowpower_acknowledge, 1'h1);
		@(posedge sys_clk) node_dom <= 1'h1;
		till(wake_irq, 1'h1);
		chk_bit(wake_irq, 1'h1);
		chk_bit(sleep_request_clear, 1'h1);
		@(posedge sys_clk) sleep_request <= 1'h0;
		repeat (8) @(posedge sys_clk);
		node_dom <= 1'h0;
		till(lowpower_acknowledge, 1'h0);
		chk_bit(lowpower_acknowledge, 1'h0);
		// No auto wake: activity alone must not end sleep
		@(posedge sys_clk) sleep_request <= 1'h1;
		auto_wake_select <= 1'h0;
		wake_irq_enable <= 1'h0;
		till(core_clk_enable, 1'h0);
		@(posedge sys_clk) node_dom <= 1'h1;
		repeat (8) @(posedge sys_clk);
		node_dom <= 1'h0;
		repeat (2 * BC) @(negedge sys_clk);
		chk_bit(lowpower_acknowledge, 1'h1);
		chk_bit(core_clk_enable, 1'h0);
		@(posedge sys_clk) sleep_request <= 1'h0;
		settle(lowpower_acknowledge);
		// Fill with the mailbox stalled, then drain
		i = 0;
		@(posedge sys_clk) rx_word_valid <= 1'h1;
		repeat (40) begin
			@(posedge sys_clk);
			if (rx_word_ready === 1'h1) begin
				i++;
				rx_word_data <= i * K;
			end
		end
		rx_word_valid <= 1'h0;
		mbox_ready <= 1'h1;
		chk_word(i, FIFO_DEPTH + 1);
		i = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (mbox_valid === 1'h1) begin
				chk_word(mbox_data, i * K);
				i++;
			end
		end
		chk_word(i, FIFO_DEPTH + 1);
		close_out();
	end
endmodule
`default_nettype wire
